/* File: include/asq_pkg.sv */
// Package: register map, field layout and timing constants for sequencer 0
package asq_pkg;
  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_UNDERFLOW    = 12'h018;
  localparam logic [11:0] OFF_AVERAGING    = 12'h030;
  localparam logic [11:0] OFF_INPUT_SELECT = 12'h040;
  localparam logic [11:0] OFF_SAMPLE_CTRL  = 12'h044;
  localparam logic [11:0] OFF_RESULT_FIFO  = 12'h048;
  localparam logic [11:0] OFF_OVERFLOW     = 12'h050;
  localparam logic [11:0] OFF_START        = 12'h054;
  localparam logic [11:0] OFF_INT_STATUS   = 12'h058;
  localparam logic [11:0] OFF_INT_MASK     = 12'h05C;
  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int SLOT_W       = 4;
  localparam int SEL_W        = 3;
  localparam int CTL_DIFF     = 0;
  localparam int CTL_LAST     = 1;
  localparam int CTL_IE       = 2;
  localparam int CTL_TEMP     = 3;
  localparam int RESULT_W     = 10;
  localparam int AVG_W        = 3;
  localparam logic [2:0] AVG_MAX = 3'h6;
  // Interrupt status bits
  localparam int IRQ_SAMPLE   = 0;
  localparam int IRQ_OVERFLOW = 1;
  localparam int IRQ_UNDERFLOW = 2;
  localparam int IRQ_W        = 3;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0]  RST_AVG  = 3'h0;
  // ------------------------------------------------------------
  // Timing: fixed converter hold of the mux before sampling
  // ------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  localparam int SETTLE_NS     = 20;
  localparam int SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CONV   = 2'b10,
    ST_STORE  = 2'b11
  } asq_state_t;
endpackage

/* File: src/asq_fifo_mem.sv */
// Result FIFO storage: small memory with registered read data
`timescale 1ns/1ps
module asq_fifo_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             sys_clk_in,
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  initial begin
    if (DEPTH != (1 << AW)) begin
      $error("DEPTH must equal 2**AW");
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule

/* File: src/asq_averager.sv */
// Hardware averager: accumulates 2**exponent conversions, outputs the mean
`timescale 1ns/1ps
module asq_averager #(
  parameter int DATA_W = 10
) (
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  input  wire logic              start_in,
  input  wire logic [2:0]        exp_in,
  input  wire logic              sample_valid_in,
  input  wire logic [DATA_W-1:0] sample_in,
  output logic                   done_out,
  output logic      [DATA_W-1:0] result_out
);
  localparam int ACC_W = DATA_W + 7;
  logic [ACC_W-1:0] acc_q;
  logic [6:0]       cnt_q;
  logic [2:0]       exp_q;
  logic [ACC_W-1:0] sum;
  logic [7:0]       total;
  initial begin
    if (DATA_W < 1) begin
      $error("DATA_W too small");
    end
  end
  assign sum   = acc_q + ACC_W'(sample_in);
  assign total = 8'(8'h01 << exp_q);
  // Exponent 7 averages 128 samples here; software must not rely on it
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      acc_q      <= '0;
      cnt_q      <= '0;
      exp_q      <= 3'h0;
      done_out   <= 1'b0;
      result_out <= '0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        acc_q <= '0;
        cnt_q <= '0;
        exp_q <= exp_in;
      end else if (sample_valid_in) begin
        if ({1'b0, cnt_q} + 8'h01 == total) begin // R2
          result_out <= DATA_W'(sum >> exp_q); // R2
          done_out   <= 1'b1;
          acc_q      <= '0;
          cnt_q      <= '0;
        end else begin
          acc_q <= sum;
          cnt_q <= cnt_q + 7'h01;
        end
      end
    end
  end
endmodule

/* File: src/asq_seq0.sv */
// Sample sequencer 0: slot configuration, averaging, result FIFO, status
`timescale 1ns/1ps
// Contract
// R1: Software programs averaging exponent only 0..6; it applies to all samples.
// R2: Each stored result averages two-to-the-exponent consecutive conversions.
// R3: Sequencer supports up to eight samples, one slot per sample.
// R4: Slot k input select is bits 4k+2..4k; bit 4k+3 reserved.
// R5: Slot k control nibble: temp 4k+3, irq 4k+2, last 4k+1, diff 4k.
// R6: Software sets the last-sample flag on exactly one slot.
// R7: Sequence stops after the flagged slot; later slots are ignored.
// R8: Differential select samples the slot's inputs as a differential pair.
// R9: In differential mode the select value is a pair number i.
// R10: Software never requests differential mode with temperature sensor.
// R11: Slot interrupt enable raises raw interrupt at end of its conversion.
// R12: Result FIFO reads return 10-bit results in sample order.
// R13: Overflow and underflow of the FIFO are recorded in status registers.
module asq_seq0 #(
  parameter int DEPTH = 8
) (
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  output logic      [2:0]  mux_sel_out,
  output logic             mux_diff_out,
  output logic             mux_temp_out,
  output logic             conv_start_out,
  input  wire logic        conv_done_in,
  input  wire logic [9:0]  conv_data_in,
  output logic             busy_out,
  output logic             irq_out
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || DEPTH != (1 << AW)) begin
      $error("DEPTH must be a power of two, at least 2");
    end
  end
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0]           sel_q;
  logic [31:0]           ctl_q;
  logic [2:0]            avg_q;
  logic [6:0]            nconv_q;
  logic                  ovf_q;
  logic                  unf_q;
  logic [2:0]            ists_q;
  logic [2:0]            imask_q;
  asq_pkg::asq_state_t   state_q;
  logic [2:0]            slot_q;
  logic [3:0]            settle_q;
  logic [AW:0]           wp_q;
  logic [AW:0]           rp_q;
  logic                  rd_fifo_q;
  logic                  rd_empty_q;
  logic [11:0]           raddr_q;
  logic [9:0]            mem_rdata;
  logic                  avg_done;
  logic [9:0]            avg_result;
  logic                  fifo_full;
  logic                  fifo_empty;
  logic                  start_req;
  logic                  rd_fifo;
  logic                  push;
  logic                  ovf_ev;
  logic                  unf_ev;
  logic                  smp_ev;
  logic [3:0]            ctl_nib;
  logic [3:0]            sel_nib;

  function automatic logic [3:0] nib(input logic [31:0] w,
                                     input logic [2:0] k);
    nib = w[{k, 2'b00} +: asq_pkg::SLOT_W];
  endfunction

  assign fifo_empty = (wp_q == rp_q);
  assign fifo_full  = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign start_req  = wr_in && addr_in == asq_pkg::OFF_START && wdata_in[0];
  assign rd_fifo    = rd_in && addr_in == asq_pkg::OFF_RESULT_FIFO;
  assign ctl_nib    = nib(ctl_q, slot_q);
  assign sel_nib    = nib(sel_q, slot_q);
  assign push       = avg_done && !fifo_full;
  assign ovf_ev     = avg_done && fifo_full; // R13
  assign unf_ev     = rd_fifo && fifo_empty; // R13
  assign smp_ev     = avg_done && ctl_nib[asq_pkg::CTL_IE]; // R11

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      sel_q   <= asq_pkg::RST_WORD;
      ctl_q   <= asq_pkg::RST_WORD;
      avg_q   <= asq_pkg::RST_AVG;
      imask_q <= 3'h0;
    end else if (wr_in) begin
      case (addr_in)
        asq_pkg::OFF_INPUT_SELECT: sel_q <= wdata_in & 32'h7777_7777; // R4
        asq_pkg::OFF_SAMPLE_CTRL:  ctl_q <= wdata_in; // R5
        asq_pkg::OFF_AVERAGING:    avg_q <= wdata_in[2:0]; // R1
        asq_pkg::OFF_INT_MASK:     imask_q <= wdata_in[2:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sequencer state machine
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state_q        <= asq_pkg::ST_IDLE;
      slot_q         <= 3'h0;
      settle_q       <= 4'h0;
      nconv_q        <= 7'h00;
      conv_start_out <= 1'b0;
      busy_out       <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      case (state_q)
        asq_pkg::ST_IDLE: begin
          if (start_req) begin
            slot_q   <= 3'h0; // R3
            settle_q <= 4'(asq_pkg::SETTLE_CYC);
            state_q  <= asq_pkg::ST_SETTLE;
            busy_out <= 1'b1;
          end
        end
        asq_pkg::ST_SETTLE: begin
          if (settle_q <= 4'h1) begin
            conv_start_out <= 1'b1;
            nconv_q        <= 7'h00;
            state_q        <= asq_pkg::ST_CONV;
          end else begin
            settle_q <= settle_q - 4'h1;
          end
        end
        asq_pkg::ST_CONV: begin
          // Restart only while raw conversions are still owed, so no
          // stray conversion runs on into the next slot
          if (avg_done) begin
            state_q <= asq_pkg::ST_STORE;
          end else if (conv_done_in) begin
            nconv_q <= nconv_q + 7'h01;
            if ({1'b0, nconv_q} + 8'h01 != 8'(8'h01 << avg_q)) begin // R2
              conv_start_out <= 1'b1;
            end
          end
        end
        asq_pkg::ST_STORE: begin
          if (ctl_nib[asq_pkg::CTL_LAST] || slot_q == 3'h7) begin // R7
            state_q  <= asq_pkg::ST_IDLE;
            busy_out <= 1'b0;
          end else begin
            slot_q   <= slot_q + 3'h1;
            settle_q <= 4'(asq_pkg::SETTLE_CYC);
            state_q  <= asq_pkg::ST_SETTLE;
          end
        end
        default: state_q <= asq_pkg::ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Analog mux steering
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      mux_sel_out  <= 3'h0;
      mux_diff_out <= 1'b0;
      mux_temp_out <= 1'b0;
    end else begin
      // Select value doubles as pair number when differential
      mux_sel_out  <= sel_nib[2:0]; // R4 R9
      mux_diff_out <= ctl_nib[asq_pkg::CTL_DIFF]; // R8
      mux_temp_out <= ctl_nib[asq_pkg::CTL_TEMP]; // R5
    end
  end

  asq_averager #(.DATA_W(asq_pkg::RESULT_W)) u_avg (
    .sys_clk_in      (sys_clk_in),
    .resetn_in       (resetn_in),
    .start_in        (state_q == asq_pkg::ST_SETTLE),
    .exp_in          (avg_q),
    .sample_valid_in (conv_done_in && state_q == asq_pkg::ST_CONV),
    .sample_in       (conv_data_in),
    .done_out        (avg_done),
    .result_out      (avg_result)
  );

  // ------------------------------------------------------------
  // Result FIFO
  // ------------------------------------------------------------
  asq_fifo_mem #(.WIDTH(asq_pkg::RESULT_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .sys_clk_in  (sys_clk_in),
    .wr_en_in    (push),
    .wr_addr_in  (wp_q[AW-1:0]),
    .wr_data_in  (avg_result),
    .rd_addr_in  (rp_q[AW-1:0]),
    .rd_data_out (mem_rdata)
  );

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1; // R12
      end
      // Empty read leaves the pointer alone
      if (rd_fifo && !fifo_empty) begin
        rp_q <= rp_q + 1'b1; // R12
      end
    end
  end

  // ------------------------------------------------------------
  // Status and interrupt: set beats write-one-to-clear
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      ovf_q  <= 1'b0;
      unf_q  <= 1'b0;
      ists_q <= 3'h0;
    end else begin
      ovf_q <= ovf_ev | (ovf_q & ~(wr_in && addr_in == asq_pkg::OFF_OVERFLOW
                                  && wdata_in[0])); // R13
      unf_q <= unf_ev | (unf_q & ~(wr_in && addr_in == asq_pkg::OFF_UNDERFLOW
                                  && wdata_in[0])); // R13
      ists_q <= {unf_ev, ovf_ev, smp_ev}
              | (ists_q & ~((wr_in && addr_in == asq_pkg::OFF_INT_STATUS)
                            ? wdata_in[2:0] : 3'h0)); // R11
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(({unf_ev, ovf_ev, smp_ev} | ists_q) & imask_q); // R11
    end
  end

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rd_fifo_q  <= 1'b0;
      rd_empty_q <= 1'b0;
      raddr_q    <= 12'h000;
    end else begin
      rd_fifo_q  <= rd_fifo;
      rd_empty_q <= fifo_empty;
      raddr_q    <= rd_in ? addr_in : 12'hFFF;
    end
  end

  always_comb begin
    case (raddr_q)
      asq_pkg::OFF_INPUT_SELECT: rdata_out = sel_q;
      asq_pkg::OFF_SAMPLE_CTRL:  rdata_out = ctl_q;
      asq_pkg::OFF_AVERAGING:    rdata_out = {29'h0, avg_q};
      asq_pkg::OFF_RESULT_FIFO:
        rdata_out = (rd_fifo_q && !rd_empty_q) ? {22'h0, mem_rdata} : 32'h0;
      asq_pkg::OFF_OVERFLOW:     rdata_out = {31'h0, ovf_q};
      asq_pkg::OFF_UNDERFLOW:    rdata_out = {31'h0, unf_q};
      asq_pkg::OFF_START:        rdata_out = {31'h0, busy_out};
      asq_pkg::OFF_INT_STATUS:   rdata_out = {29'h0, ists_q};
      asq_pkg::OFF_INT_MASK:     rdata_out = {29'h0, imask_q};
      default:                   rdata_out = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  stop_at_last_a: assert property ( // R7
    state_q == asq_pkg::ST_STORE && ctl_nib[asq_pkg::CTL_LAST]
    |=> state_q == asq_pkg::ST_IDLE && !busy_out)
    else $error("sequence continued past last slot");
  next_slot_a: assert property ( // R3
    state_q == asq_pkg::ST_STORE && !ctl_nib[asq_pkg::CTL_LAST]
    && slot_q != 3'h7 |=> slot_q == $past(slot_q) + 3'h1)
    else $error("slot did not advance");
  mux_select_a: assert property ( // R4
    state_q == asq_pkg::ST_CONV && $stable(slot_q)
    |-> mux_sel_out == sel_q[{slot_q, 2'b00} +: 3])
    else $error("mux select mismatch");
  diff_mode_a: assert property ( // R8
    state_q == asq_pkg::ST_CONV && $stable(slot_q)
    |-> mux_diff_out == ctl_q[{slot_q, 2'b00}])
    else $error("differential select mismatch");
  temp_select_a: assert property ( // R5
    state_q == asq_pkg::ST_CONV && $stable(slot_q)
    |-> mux_temp_out == ctl_q[{slot_q, 2'b00} + 3'd3])
    else $error("temperature select mismatch");
  sample_irq_a: assert property ( // R11
    smp_ev && imask_q[asq_pkg::IRQ_SAMPLE]
    |=> irq_out && ists_q[asq_pkg::IRQ_SAMPLE])
    else $error("sample interrupt not raised");
  overflow_flag_a: assert property ( // R13
    ovf_ev |=> ovf_q) else $error("overflow not recorded");
  underflow_flag_a: assert property ( // R13
    unf_ev |=> unf_q && $stable(rp_q)) else $error("underflow not recorded");
  fifo_order_a: assert property ( // R12
    rd_fifo && !fifo_empty |=> rp_q == $past(rp_q) + 1'b1)
    else $error("read pointer did not advance");
  avg_passthru_a: assert property ( // R2
    avg_q == 3'h0 && state_q == asq_pkg::ST_CONV && conv_done_in
    |=> avg_done && avg_result == $past(conv_data_in))
    else $error("exponent zero did not pass through");

  seq_run_c:   cover property (start_req ##[1:200] state_q == asq_pkg::ST_STORE);
  overflow_c:  cover property (ovf_ev);
  underflow_c: cover property (unf_ev);
  irq_c:       cover property (irq_out);
endmodule

/* File: tb/asq_conv_model.sv */
// Converter model: one result per start, after a latency set by the bench
`timescale 1ns/1ps
module asq_conv_model (
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       conv_start_in,
  input  wire logic [2:0] sel_in,
  input  wire logic       diff_in,
  input  wire logic       temp_in,
  input  wire logic [3:0] lat_in,
  output logic            conv_done_out,
  output logic      [9:0] conv_data_out
);
  logic [3:0] cnt_q;
  logic       act_q;
  logic [4:0] code_q;
  int         n_q;
  // Result encodes the selection, so a wrong mux setting shows in the data
  always_ff @(posedge sys_clk_in) begin
    conv_done_out <= 1'b0;
    if (!resetn_in) begin
      act_q         <= 1'b0;
      cnt_q         <= 4'h0;
      n_q           <= 0;
      conv_data_out <= 10'h155;
    end else if (act_q && cnt_q <= 4'h1) begin
      act_q         <= 1'b0;
      conv_done_out <= 1'b1;
      conv_data_out <= 10'(code_q) * 10'h01E + 10'((n_q % 4) * 3);
      n_q           <= n_q + 1;
    end else begin
      // Data is only valid with done; toggle so stale values never match
      conv_data_out <= ~conv_data_out;
      if (act_q) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (conv_start_in) begin
        act_q  <= 1'b1;
        cnt_q  <= lat_in;
        code_q <= {temp_in, diff_in, sel_in};
      end
    end
  end
endmodule

/* File: tb/asq_seq0_tb.sv */
// Testbench: random and corner sequences for sample sequencer 0
`timescale 1ns/1ps
module asq_seq0_tb;
  logic        sys_clk_in;
  logic        resetn_in;
  logic [11:0] addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata_out;
  logic [2:0]  mux_sel_out;
  logic        mux_diff_out;
  logic        mux_temp_out;
  logic        conv_start_out;
  logic        conv_done_in;
  logic [9:0]  conv_data_in;
  logic        busy_out;
  logic        irq_out;
  logic [3:0]  lat;
  int          bad_count;
  int          n_compared;
  int          nexp;
  logic [31:0] seed;
  logic [31:0] expq[$];

  asq_seq0 #(.DEPTH(8)) i_dut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .mux_sel_out(mux_sel_out),
    .mux_diff_out(mux_diff_out), .mux_temp_out(mux_temp_out),
    .conv_start_out(conv_start_out), .conv_done_in(conv_done_in),
    .conv_data_in(conv_data_in), .busy_out(busy_out), .irq_out(irq_out));

  asq_conv_model i_conv (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .conv_start_in(conv_start_out), .sel_in(mux_sel_out),
    .diff_in(mux_diff_out), .temp_in(mux_temp_out), .lat_in(lat),
    .conv_done_out(conv_done_in), .conv_data_out(conv_data_in));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  function automatic logic [9:0] conv_val(input logic [4:0] c, input int n);
    return 10'(c) * 10'h01E + 10'((n % 4) * 3);
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
    @(posedge sys_clk_in);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Expected results: mean of 2**avg model values per slot up to the last
  task automatic plan(input logic [31:0] mx, input logic [31:0] ct,
                      input logic [2:0] av, output logic ie);
    logic [4:0]  code;
    logic [16:0] sum;
    logic        stop;
    ie   = 1'b0;
    stop = 1'b0;
    for (int s = 0; s < 8; s++) begin
      if (!stop) begin
        code = {ct[4*s+3], ct[4*s], mx[4*s +: 3]};
        sum  = 17'h00000;
        for (int j = 0; j < (1 << av); j++) begin
          sum += 17'(conv_val(code, nexp));
          nexp++;
        end
        expq.push_back(32'(sum >> av));
        ie   = ie | ct[4*s+2];
        stop = ct[4*s+1];
      end
    end
  endtask

  task automatic run_seq();
    wr(asq_pkg::OFF_START, 32'h00000001);
    rdc(asq_pkg::OFF_START, 32'h00000001);
    for (int i = 0; i < 40000 && busy_out !== 1'b0; i++) begin
      @(posedge sys_clk_in);
    end
    if (busy_out !== 1'b0) begin
      bad_count++;
      conclude();
    end
    rdc(asq_pkg::OFF_START, 32'h00000000);
  endtask

  task automatic drain();
    logic [31:0] d;
    while (expq.size() > 0) begin
      rd(asq_pkg::OFF_RESULT_FIFO, d);
      chk(d, expq.pop_front());
    end
  endtask

  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    logic [31:0] mx;
    logic [31:0] ct;
    logic [31:0] mk;
    logic [2:0]  av;
    logic        ie;
    int          e;
    resetn_in = 1'b0;
    addr_in = 12'h000;
    wdata_in = 32'h00000000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    lat = 4'h1;
    bad_count = 0;
    n_compared = 0;
    nexp = 0;
    seed = 32'h65B5EC3D;
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    rdc(asq_pkg::OFF_INPUT_SELECT, 32'h00000000);
    rdc(asq_pkg::OFF_SAMPLE_CTRL, 32'h00000000);
    rdc(asq_pkg::OFF_AVERAGING, 32'h00000000);
    rdc(asq_pkg::OFF_INT_STATUS, 32'h00000000);
    wr(asq_pkg::OFF_INPUT_SELECT, 32'hFFFFFFFF);
    rdc(asq_pkg::OFF_INPUT_SELECT, 32'h77777777);
    wr(asq_pkg::OFF_SAMPLE_CTRL, 32'hFFFFFFFF);
    rdc(asq_pkg::OFF_SAMPLE_CTRL, 32'hFFFFFFFF);
    wr(asq_pkg::OFF_AVERAGING, 32'hFFFFFFFF);
    rdc(asq_pkg::OFF_AVERAGING, 32'h00000007);
    wr(12'h100, 32'hFFFFFFFF);
    rdc(12'h100, 32'h00000000);
    // Corners first: last flag on slot 0 unaveraged, slot 7 with 64
    for (int it = 0; it < 10; it++) begin
      seed = lfsr(seed);
      mx = seed;
      seed = lfsr(seed);
      ct = seed;
      seed = lfsr(seed);
      av = (it == 0) ? 3'h0 : (it == 1) ? 3'h6 : 3'(seed[2:0] % 7);
      e = (it == 0) ? 0 : (it == 1) ? 7 : int'(seed[6:4]);
      lat <= 4'(seed[10:8]) + 4'h1;
      mk = {29'h0, seed[14:12]};
      for (int k = 0; k < 8; k++) begin
        ct[4*k+1] = (k == e);
        if (ct[4*k+3]) ct[4*k] = 1'b0;
      end
      wr(asq_pkg::OFF_AVERAGING, {29'h0, av});
      wr(asq_pkg::OFF_INPUT_SELECT, mx);
      wr(asq_pkg::OFF_SAMPLE_CTRL, ct);
      wr(asq_pkg::OFF_INT_MASK, mk);
      plan(mx, ct, av, ie);
      run_seq();
      rdc(asq_pkg::OFF_INT_STATUS, {31'h0, ie});
      chk({31'h0, irq_out}, {31'h0, mk[0] & ie});
      drain();
      rdc(asq_pkg::OFF_RESULT_FIFO, 32'h00000000);
      rdc(asq_pkg::OFF_UNDERFLOW, 32'h00000001);
      rdc(asq_pkg::OFF_INT_STATUS, {29'h0, 2'b10, ie});
      chk({31'h0, irq_out}, {31'h0, (mk[0] & ie) | mk[2]});
      wr(asq_pkg::OFF_UNDERFLOW, 32'h00000001);
      wr(asq_pkg::OFF_INT_STATUS, 32'h00000007);
      rdc(asq_pkg::OFF_INT_STATUS, 32'h00000000);
      chk({31'h0, irq_out}, 32'h00000000);
    end
    // Two full runs into an eight-deep FIFO; the later results drop
    wr(asq_pkg::OFF_AVERAGING, 32'h00000000);
    wr(asq_pkg::OFF_SAMPLE_CTRL, 32'h20000000);
    plan(mx, 32'h20000000, 3'h0, ie);
    run_seq();
    plan(mx, 32'h20000000, 3'h0, ie);
    repeat (8) void'(expq.pop_back());
    run_seq();
    rdc(asq_pkg::OFF_OVERFLOW, 32'h00000001);
    rdc(asq_pkg::OFF_INT_STATUS, 32'h00000002);
    drain();
    wr(asq_pkg::OFF_OVERFLOW, 32'h00000001);
    rdc(asq_pkg::OFF_OVERFLOW, 32'h00000000);
    conclude();
  end
endmodule
